/* File: verilog/sensor_fault_diagnostics.sv */
/*
  Fault supervision of a magnetic position sensor: latches self-test
  results into two status words, selects the PWM error duty, builds the
  slow-channel diagnostic payload and requests a device reset on fatal
  controller faults. Assumes raw fault inputs are asynchronous levels and
  that the programming interface reads the status words as plain ports.
*/
`timescale 1ns/1ps
module sensor_fault_diagnostics (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic variant_fixed,
  input wire logic pwm_mode,
  input wire logic supply_report_en,
  input wire logic error_high_sel,
  input wire logic [9:0] standard_error_level_setting,
  input wire logic [9:0] magnet_loss_output_setting,
  input wire logic sent_mag_loss,
  input wire logic [15:0] primary_fault_raw,
  input wire logic [15:0] secondary_fault_raw,
  input wire logic adc_clip_raw,
  input wire logic status_clear,
  output logic [15:0] fault_status_primary,
  output logic [15:0] fault_status_secondary,
  output logic fault_active,
  output logic pwm_error_force,
  output logic [9:0] pwm_error_duty,
  output logic [7:0] slow_msg_id,
  output logic [11:0] slow_msg_data,
  output logic selftest_strobe,
  output logic startup_done,
  output logic device_reset_req
);

  // ---------------------------------------------------------------
  // Self-test scheduling
  // ---------------------------------------------------------------
  fault_diag_pkg::test_phase_e phase_r;
  fault_diag_pkg::test_phase_e phase_nxt;
  logic [11:0] tick_r;
  logic [11:0] tick_nxt;
  logic [3:0] rst_cnt_r;
  logic [3:0] rst_cnt_nxt;
  logic strobe;
  logic [15:0] prim_word;
  logic [15:0] sec_word;
  logic fatal;
  logic clip_sync1_r;
  logic clip_sync2_r;
  logic clip_r;
  logic clip_nxt;

  assign strobe = (tick_r == fault_diag_pkg::SELFTEST_CNT_MAX);
  assign fatal = |(sec_word & fault_diag_pkg::SECONDARY_RESET_MASK);

  always_comb begin
    phase_nxt = phase_r;
    tick_nxt = strobe ? 12'h000 : tick_r + 12'h001;
    rst_cnt_nxt = rst_cnt_r;
    unique case (phase_r)
      fault_diag_pkg::ST_STARTUP: begin
        if (fatal) begin
          phase_nxt = fault_diag_pkg::ST_HOLD;
          rst_cnt_nxt = fault_diag_pkg::RESET_PULSE_CYCLES;
        end else if (strobe) begin
          phase_nxt = fault_diag_pkg::ST_RUN;
        end
      end
      fault_diag_pkg::ST_RUN: begin
        if (fatal) begin
          phase_nxt = fault_diag_pkg::ST_HOLD;
          rst_cnt_nxt = fault_diag_pkg::RESET_PULSE_CYCLES;
        end
      end
      fault_diag_pkg::ST_HOLD: begin
        if (rst_cnt_r != 4'h0) begin
          rst_cnt_nxt = rst_cnt_r - 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phase_r <= fault_diag_pkg::ST_STARTUP;
      tick_r <= 12'h000;
      rst_cnt_r <= 4'h0;
    end else if (clk_en) begin
      phase_r <= phase_nxt;
      tick_r <= tick_nxt;
      rst_cnt_r <= rst_cnt_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Status words
  // ---------------------------------------------------------------
  logic [15:0] prim_raw;
  logic [15:0] sec_raw;

  always_comb begin
    prim_raw = 16'h0000;
    prim_raw[fault_diag_pkg::P_DSP_CHECK] =
      primary_fault_raw[fault_diag_pkg::P_DSP_CHECK];
    prim_raw[fault_diag_pkg::P_NVM_CRC] =
      primary_fault_raw[fault_diag_pkg::P_NVM_CRC];
    prim_raw[fault_diag_pkg::P_MEM_CRC] =
      primary_fault_raw[fault_diag_pkg::P_MEM_CRC];
    prim_raw[fault_diag_pkg::P_TEMP_RANGE] =
      primary_fault_raw[fault_diag_pkg::P_TEMP_RANGE];
    prim_raw[fault_diag_pkg::P_TEMP_PLAUS] =
      primary_fault_raw[fault_diag_pkg::P_TEMP_PLAUS];
    prim_raw[fault_diag_pkg::P_OVERTEMP_HW] =
      primary_fault_raw[fault_diag_pkg::P_OVERTEMP_HW];
    prim_raw[fault_diag_pkg::P_HALL_SUPPLY] =
      primary_fault_raw[fault_diag_pkg::P_HALL_SUPPLY];
    prim_raw[fault_diag_pkg::P_HALL_CURRENT] =
      primary_fault_raw[fault_diag_pkg::P_HALL_CURRENT];
    prim_raw[fault_diag_pkg::P_ADC_STUCK] =
      primary_fault_raw[fault_diag_pkg::P_ADC_STUCK];
    prim_raw[fault_diag_pkg::P_DECIM_OVF] =
      primary_fault_raw[fault_diag_pkg::P_DECIM_OVF];
    prim_raw[fault_diag_pkg::P_MAG_HIGH] =
      primary_fault_raw[fault_diag_pkg::P_MAG_HIGH];
    prim_raw[fault_diag_pkg::P_MAG_LOW] =
      primary_fault_raw[fault_diag_pkg::P_MAG_LOW];
    prim_raw[fault_diag_pkg::P_POS_HIGH] =
      primary_fault_raw[fault_diag_pkg::P_POS_HIGH];
    prim_raw[fault_diag_pkg::P_POS_LOW] =
      primary_fault_raw[fault_diag_pkg::P_POS_LOW];
    sec_raw = secondary_fault_raw & fault_diag_pkg::SECONDARY_MASK;
    sec_raw[fault_diag_pkg::S_AUX_ADC_B] =
      secondary_fault_raw[fault_diag_pkg::S_AUX_ADC_A];
  end

  // Sticky words, a set beats a clear in the same cycle
  status_word #(.MASK(fault_diag_pkg::PRIMARY_MASK)) u_primary (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .raw(prim_raw),
    .sample(1'b1),
    .clear(status_clear),
    .word(prim_word)
  );

  status_word #(.MASK(fault_diag_pkg::SECONDARY_MASK)) u_secondary (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .raw(sec_raw),
    .sample(1'b1),
    .clear(status_clear),
    .word(sec_word)
  );

  always_comb begin
    clip_nxt = clip_r;
    if (status_clear) begin
      clip_nxt = 1'b0;
    end
    if (clip_sync2_r) begin
      clip_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      clip_sync1_r <= 1'b0;
      clip_sync2_r <= 1'b0;
      clip_r <= 1'b0;
    end else if (clk_en) begin
      clip_sync1_r <= adc_clip_raw;
      clip_sync2_r <= clip_sync1_r;
      clip_r <= clip_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Output selection
  // ---------------------------------------------------------------
  logic [15:0] prim_out_nxt;
  logic [15:0] sec_out_nxt;
  logic [9:0] duty_nxt;
  logic force_nxt;
  logic [11:0] slow_nxt;
  logic general_err;
  logic supply_err;

  assign supply_err = sec_word[fault_diag_pkg::S_UNDERVOLT] |
    sec_word[fault_diag_pkg::S_OVERVOLT];
  // Fatal bits reset the device instead of forcing an error duty
  assign general_err = |prim_word |
    sec_word[fault_diag_pkg::S_AUX_ADC_A] |
    sec_word[fault_diag_pkg::S_AUX_ADC_B] |
    sec_word[fault_diag_pkg::S_ANALOG_SUP] |
    sec_word[fault_diag_pkg::S_DIGITAL_SUP];

  always_comb begin
    prim_out_nxt = prim_word;
    sec_out_nxt = sec_word & fault_diag_pkg::SECONDARY_READ_MASK;
    force_nxt = pwm_mode && (general_err || supply_err);
    duty_nxt = 10'h000;
    if (general_err) begin
      if (variant_fixed) begin
        duty_nxt = prim_word[fault_diag_pkg::P_MAG_LOW] ?
          magnet_loss_output_setting : standard_error_level_setting;
      end else begin
        duty_nxt = error_high_sel ? fault_diag_pkg::DUTY_ERR_HIGH :
          fault_diag_pkg::DUTY_ERR_LOW;
      end
    end else if (supply_err) begin
      if (supply_report_en) begin
        duty_nxt = fault_diag_pkg::DUTY_SUPPLY;
      end else begin
        force_nxt = 1'b0;
      end
    end
    slow_nxt = 12'h000;
    slow_nxt[fault_diag_pkg::SLOW_ALWAYS_ONE] = 1'b1;
    slow_nxt[fault_diag_pkg::SLOW_MEM] =
      prim_word[fault_diag_pkg::P_NVM_CRC] |
      prim_word[fault_diag_pkg::P_MEM_CRC];
    slow_nxt[fault_diag_pkg::SLOW_ADC_DSP] =
      prim_word[fault_diag_pkg::P_DSP_CHECK] |
      prim_word[fault_diag_pkg::P_ADC_STUCK] |
      sec_word[fault_diag_pkg::S_AUX_ADC_A];
    slow_nxt[fault_diag_pkg::SLOW_REGULATOR] =
      sec_word[fault_diag_pkg::S_ANALOG_SUP] |
      sec_word[fault_diag_pkg::S_DIGITAL_SUP];
    slow_nxt[fault_diag_pkg::SLOW_ADC_CLIP] = clip_r;
    slow_nxt[fault_diag_pkg::SLOW_TEMP] =
      prim_word[fault_diag_pkg::P_TEMP_PLAUS] |
      prim_word[fault_diag_pkg::P_TEMP_RANGE];
    slow_nxt[fault_diag_pkg::SLOW_PATH] =
      prim_word[fault_diag_pkg::P_DECIM_OVF] |
      prim_word[fault_diag_pkg::P_POS_HIGH] |
      prim_word[fault_diag_pkg::P_POS_LOW];
    slow_nxt[fault_diag_pkg::SLOW_OVERVOLT] =
      sec_word[fault_diag_pkg::S_OVERVOLT];
    slow_nxt[fault_diag_pkg::SLOW_UNDERVOLT] =
      sec_word[fault_diag_pkg::S_UNDERVOLT];
    slow_nxt[fault_diag_pkg::SLOW_HALL] =
      prim_word[fault_diag_pkg::P_HALL_SUPPLY] |
      prim_word[fault_diag_pkg::P_HALL_CURRENT];
    slow_nxt[fault_diag_pkg::SLOW_MAG] = !sent_mag_loss &&
      (prim_word[fault_diag_pkg::P_MAG_HIGH] |
      prim_word[fault_diag_pkg::P_MAG_LOW]);
  end

  logic [15:0] prim_out_r;
  logic [15:0] sec_out_r;
  logic [9:0] duty_r;
  logic force_r;
  logic [11:0] slow_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prim_out_r <= fault_diag_pkg::STATUS_RESET;
      sec_out_r <= fault_diag_pkg::STATUS_RESET;
      duty_r <= 10'h000;
      force_r <= 1'b0;
      slow_r <= 12'h000;
    end else if (clk_en) begin
      prim_out_r <= prim_out_nxt;
      sec_out_r <= sec_out_nxt;
      duty_r <= duty_nxt;
      force_r <= force_nxt;
      slow_r <= slow_nxt;
    end
  end

  assign fault_status_primary = prim_out_r;
  assign fault_status_secondary = sec_out_r;
  assign pwm_error_force = force_r;
  assign pwm_error_duty = duty_r;
  assign fault_active = force_r;
  assign slow_msg_id = fault_diag_pkg::SLOW_MSG_ID;
  assign slow_msg_data = slow_r;
  assign selftest_strobe = strobe;
  assign startup_done = (phase_r != fault_diag_pkg::ST_STARTUP);
  assign device_reset_req = (phase_r == fault_diag_pkg::ST_HOLD) &&
    (rst_cnt_r != 4'h0);

endmodule : sensor_fault_diagnostics

/* File: verilog/fault_diag_pkg.sv */
/*
  Package for the fault supervision block: status word bit positions,
  PWM error duty codes, slow-channel message layout and timing counts.
  Assumes duty cycles are expressed in tenths of a percent (0..1000).
*/
package fault_diag_pkg;

  // ---------------------------------------------------------------
  // Primary status word bit positions
  // ---------------------------------------------------------------
  localparam int P_DSP_CHECK = 15;
  localparam int P_NVM_CRC = 14;
  localparam int P_MEM_CRC = 13;
  localparam int P_TEMP_RANGE = 12;
  localparam int P_TEMP_PLAUS = 11;
  localparam int P_HALL_SUPPLY = 10;
  localparam int P_OVERTEMP_HW = 9;
  localparam int P_ADC_STUCK = 7;
  localparam int P_DECIM_OVF = 6;
  localparam int P_MAG_HIGH = 5;
  localparam int P_MAG_LOW = 4;
  localparam int P_POS_HIGH = 3;
  localparam int P_POS_LOW = 2;
  localparam int P_HALL_CURRENT = 1;
  localparam logic [15:0] PRIMARY_MASK = 16'hFEFE;

  // ---------------------------------------------------------------
  // Secondary status word bit positions
  // ---------------------------------------------------------------
  localparam int S_AUX_ADC_A = 14;
  localparam int S_AUX_ADC_B = 12;
  localparam int S_UNDERVOLT = 11;
  localparam int S_OVERVOLT = 10;
  localparam int S_ANALOG_SUP = 9;
  localparam int S_DIGITAL_SUP = 8;
  localparam int S_MCU_SELFTEST = 7;
  localparam int S_ROM_OPCODE = 6;
  localparam int S_MEM_OPCODE = 5;
  localparam int S_ANALOG_PART = 1;
  localparam logic [15:0] SECONDARY_MASK = 16'h5FE2;
  localparam logic [15:0] SECONDARY_READ_MASK = 16'h5F00;
  localparam logic [15:0] SECONDARY_RESET_MASK = 16'h00FF;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // PWM error duty codes, tenths of a percent
  // ---------------------------------------------------------------
  localparam logic [9:0] DUTY_ERR_LOW = 10'h005;
  localparam logic [9:0] DUTY_ERR_HIGH = 10'h3E3;
  localparam logic [9:0] DUTY_SUPPLY = 10'h014;

  // ---------------------------------------------------------------
  // Slow-channel diagnostic message
  // ---------------------------------------------------------------
  localparam logic [7:0] SLOW_MSG_ID = 8'h01;
  localparam int SLOW_ALWAYS_ONE = 11;
  localparam int SLOW_MEM = 0;
  localparam int SLOW_ADC_DSP = 1;
  localparam int SLOW_REGULATOR = 2;
  localparam int SLOW_ADC_CLIP = 3;
  localparam int SLOW_TEMP = 4;
  localparam int SLOW_PATH = 5;
  localparam int SLOW_OVERVOLT = 6;
  localparam int SLOW_UNDERVOLT = 7;
  localparam int SLOW_HALL = 9;
  localparam int SLOW_MAG = 10;

  // ---------------------------------------------------------------
  // Timing: periodic self-test interval and reset pulse length
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int SELFTEST_PERIOD_US = 100;
  localparam int SELFTEST_CYCLES = SELFTEST_PERIOD_US * (CLK_HZ / 1000000);
  localparam logic [11:0] SELFTEST_CNT_MAX = 12'(SELFTEST_CYCLES - 1);
  localparam logic [3:0] RESET_PULSE_CYCLES = 4'h8;

  typedef enum logic [1:0] {
    ST_STARTUP,
    ST_RUN,
    ST_HOLD
  } test_phase_e;

endpackage : fault_diag_pkg

/* File: verilog/sticky_flag.sv */
/*
  One sticky fault flag with synchronised raw input; set wins over clear.
  Assumes raw input comes from outside the clock domain.
*/
`timescale 1ns/1ps
module sticky_flag (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic raw,
  input wire logic sample,
  input wire logic clear,
  output logic flag
);

  logic sync1_r;
  logic sync2_r;
  logic flag_r;
  logic sync1_nxt;
  logic sync2_nxt;
  logic flag_nxt;

  always_comb begin
    sync1_nxt = raw;
    sync2_nxt = sync1_r;
    flag_nxt = flag_r;
    if (clear) begin
      flag_nxt = 1'b0;
    end
    if (sample && sync2_r) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      flag_r <= 1'b0;
    end else if (clk_en) begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign flag = flag_r;

endmodule : sticky_flag

/* File: verilog/status_word.sv */
/*
  One sticky flag per position set in MASK, forming one status word; reserved bits stay zero.
  Assumes the mask parameter marks the implemented positions.
*/
`timescale 1ns/1ps
module status_word #(
  parameter logic [15:0] MASK = 16'hFFFF
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [15:0] raw,
  input wire logic sample,
  input wire logic clear,
  output logic [15:0] word
);

  for (genvar i = 0; i < 16; i++) begin : g_bit
    if (MASK[i]) begin : g_used
      sticky_flag u_flag (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .raw(raw[i]),
        .sample(sample),
        .clear(clear),
        .flag(word[i])
      );
    end else begin : g_rsvd
      assign word[i] = 1'b0;
    end
  end

endmodule : status_word

/* File: sim/fault_diag_chk.sv */
/*
  Checker for the fault supervision outputs.
  Assumes it is bound to the top module and that clk_en is held high.
*/
`timescale 1ns/1ps
module fault_diag_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic variant_fixed,
  input wire logic [15:0] primary_fault_raw,
  input wire logic [15:0] secondary_fault_raw,
  input wire logic status_clear,
  input wire logic [15:0] fault_status_primary,
  input wire logic [15:0] fault_status_secondary,
  input wire logic fault_active,
  input wire logic pwm_error_force,
  input wire logic [9:0] pwm_error_duty,
  input wire logic [7:0] slow_msg_id,
  input wire logic [11:0] slow_msg_data,
  input wire logic selftest_strobe,
  input wire logic device_reset_req
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // -------------------------------------------------------------
  // Self-test interval counter
  // -------------------------------------------------------------
  logic [11:0] gap_r;
  logic [11:0] gap_nxt;
  logic seen_r;
  logic seen_nxt;
  always_comb begin
    gap_nxt = selftest_strobe ? 12'h000 : gap_r + 12'h001;
    seen_nxt = seen_r | selftest_strobe;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      gap_r <= 12'h000;
      seen_r <= 1'b0;
    end else begin
      gap_r <= gap_nxt;
      seen_r <= seen_nxt;
    end
  end
  sequence raw_top_held;
    primary_fault_raw[15] [*4];
  endsequence
  sequence clear_quiet;
    (status_clear && primary_fault_raw == 16'h0000) [*6];
  endsequence
  sequence fatal_held;
    secondary_fault_raw[5] [*3];
  endsequence
  chk_prim_reserved: assert property (
    !fault_status_primary[8] && !fault_status_primary[0])
    else $error("primary reserved bit set");
  chk_sec_hidden: assert property (
    fault_status_secondary[7:0] == 8'h00 && !fault_status_secondary[15]
    && !fault_status_secondary[13])
    else $error("secondary hidden bit visible");
  chk_slow_id: assert property (slow_msg_id == 8'h01)
    else $error("slow message id wrong");
  chk_slow_marker: assert property (
    $past(reset_n) |-> slow_msg_data[11])
    else $error("slow payload bit 11 low");
  chk_force_cause: assert property (
    pwm_error_force |-> fault_active
    && (fault_status_primary | fault_status_secondary) != 16'h0000)
    else $error("error force without flag");
  chk_prim_latency: assert property (
    raw_top_held |-> ##[0:2] fault_status_primary[15])
    else $error("primary flag late");
  chk_aux_pair: assert property (
    fault_status_secondary[14] == fault_status_secondary[12])
    else $error("aux converter pair differs");
  chk_duty_levels: assert property (
    pwm_error_force && !variant_fixed && !$past(variant_fixed)
    && fault_status_primary != 16'h0000
    |-> pwm_error_duty inside {10'h005, 10'h3E3})
    else $error("error duty not a fault level");
  chk_fatal_reset: assert property (
    fatal_held |-> ##[1:14] device_reset_req)
    else $error("fatal fault gave no reset");
  chk_clear_drop: assert property (
    clear_quiet |-> fault_status_primary == 16'h0000)
    else $error("clear did not drop flags");
  chk_test_period: assert property (
    selftest_strobe && seen_r |-> gap_r == 12'h9C3)
    else $error("self-test interval wrong");
endmodule : fault_diag_chk

bind sensor_fault_diagnostics fault_diag_chk fault_diag_chk_i (
  .clk(clk), .reset_n(reset_n), .variant_fixed(variant_fixed),
  .primary_fault_raw(primary_fault_raw),
  .secondary_fault_raw(secondary_fault_raw), .status_clear(status_clear),
  .fault_status_primary(fault_status_primary),
  .fault_status_secondary(fault_status_secondary),
  .fault_active(fault_active), .pwm_error_force(pwm_error_force),
  .pwm_error_duty(pwm_error_duty), .slow_msg_id(slow_msg_id),
  .slow_msg_data(slow_msg_data), .selftest_strobe(selftest_strobe),
  .device_reset_req(device_reset_req));

/* File: sim/host_decoder.sv */
/*
  Host side model: decodes the PWM error duty and the slow-channel
  diagnostic frame. Assumes duty codes in tenths of a percent.
*/
`timescale 1ns/1ps
module host_decoder (
  input wire logic clk,
  input wire logic pwm_error_force,
  input wire logic [9:0] pwm_error_duty,
  input wire logic [7:0] slow_msg_id,
  input wire logic [11:0] slow_msg_data,
  output logic host_error,
  output logic host_supply,
  output logic host_frame_ok
);
  always_ff @(posedge clk) begin
    host_error <= pwm_error_force && pwm_error_duty != 10'h014;
    host_supply <= pwm_error_force && pwm_error_duty == 10'h014;
    host_frame_ok <= slow_msg_id == 8'h01 && slow_msg_data[11];
  end
endmodule : host_decoder

/* File: sim/tb_top.sv */
/*
  Self-checking bench for the fault supervision block.
  Assumes the checker binds itself and clk_en stays high.
*/
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic variant_fixed = 1'b0;
  logic supply_report_en = 1'b0;
  logic error_high_sel = 1'b0;
  logic sent_mag_loss = 1'b0;
  logic status_clear = 1'b0;
  logic pwm_mode = 1'b1;
  logic clip_raw = 1'b0;
  logic [9:0] std_lvl = 10'h000;
  logic [9:0] mag_lvl = 10'h000;
  logic [15:0] p_raw = 16'h0000;
  logic [15:0] s_raw = 16'h0000;
  logic [15:0] st_p, st_s, exp_p, exp_s;
  logic f_act, f_force, t_strobe, s_done, rst_req, h_err, h_sup, h_ok;
  logic [9:0] duty;
  logic [7:0] m_id;
  logic [11:0] m_data;
  int miscompares = 0;
  int samples_checked = 0;
  int fatal[4] = '{1, 5, 6, 7};
  int n;
  always #20 clk = ~clk;
  sensor_fault_diagnostics sensor_fault_diagnostics_i (
    .clk(clk), .reset_n(reset_n), .clk_en(1'b1),
    .variant_fixed(variant_fixed), .pwm_mode(pwm_mode),
    .supply_report_en(supply_report_en), .error_high_sel(error_high_sel),
    .standard_error_level_setting(std_lvl),
    .magnet_loss_output_setting(mag_lvl), .sent_mag_loss(sent_mag_loss),
    .primary_fault_raw(p_raw), .secondary_fault_raw(s_raw),
    .adc_clip_raw(clip_raw), .status_clear(status_clear),
    .fault_status_primary(st_p), .fault_status_secondary(st_s),
    .fault_active(f_act), .pwm_error_force(f_force),
    .pwm_error_duty(duty), .slow_msg_id(m_id), .slow_msg_data(m_data),
    .selftest_strobe(t_strobe), .startup_done(s_done),
    .device_reset_req(rst_req));
  host_decoder host_decoder_i (
    .clk(clk), .pwm_error_force(f_force), .pwm_error_duty(duty),
    .slow_msg_id(m_id), .slow_msg_data(m_data), .host_error(h_err),
    .host_supply(h_sup), .host_frame_ok(h_ok));
  // -------------------------------------------------------------
  // Compare and drive tasks
  // -------------------------------------------------------------
  task automatic report(input logic bad, input logic [15:0] g,
                        input logic [15:0] e);
    samples_checked++;
    if (bad) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : report
  task automatic cmp_word(input logic [15:0] g, input logic [15:0] e);
    report(g !== e, g, e);
  endtask : cmp_word
  task automatic cmp_duty(input logic [9:0] g, input logic [9:0] e);
    report(g !== e, {6'h00, g}, {6'h00, e});
  endtask : cmp_duty
  task automatic cmp_bit(input logic g, input logic e);
    report(g !== e, {15'h0000, g}, {15'h0000, e});
  endtask : cmp_bit
  task automatic clear_all;
    @(posedge clk);
    p_raw <= 16'h0000;
    s_raw <= 16'h0000;
    clip_raw <= 1'b0;
    status_clear <= 1'b1;
    repeat (6) @(posedge clk);
    status_clear <= 1'b0;
    exp_p = 16'h0000;
    exp_s = 16'h0000;
  endtask : clear_all
  task automatic apply(input logic [15:0] p, input logic [15:0] s);
    @(posedge clk);
    p_raw <= p;
    s_raw <= s;
    exp_p = exp_p | (p & 16'hFEFE);
    exp_s = exp_s | (s & 16'h0F00) | (s[14] ? 16'h5000 : 16'h0000);
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask : apply
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run();
  end
  initial begin
    void'($urandom(82));
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    n = 0;
    repeat (5000) begin
      @(negedge clk);
      n = n + (t_strobe === 1'b1);
    end
    cmp_word(16'(n), 16'h0002);
    cmp_bit(s_done, 1'b1);
    cmp_word(st_p, 16'h0000);
    cmp_word({4'h0, m_data}, 16'h0800);
    cmp_bit(h_ok, 1'b1);
    for (int i = 0; i < 16; i++) begin
      clear_all();
      error_high_sel <= i[0];
      sent_mag_loss <= i[0];
      apply(16'h0001 << i, 16'h0000);
      cmp_word(st_p, exp_p);
      cmp_bit(f_force, exp_p != 16'h0000);
      cmp_bit(f_act, exp_p != 16'h0000);
      cmp_bit(h_err, exp_p != 16'h0000);
      if (exp_p != 16'h0000)
        cmp_duty(duty, i[0] ? 10'h3E3 : 10'h005);
      cmp_bit(m_data[10], (i == 4 || i == 5) && !i[0]);
    end
    for (int i = 8; i < 16; i++) begin
      if (i == 12)
        continue;
      clear_all();
      supply_report_en <= 1'b1;
      apply(16'h0000, 16'h0001 << i);
      cmp_word(st_s, exp_s);
      if (i == 10 || i == 11)
        cmp_bit(h_sup, 1'b1);
    end
    clear_all();
    supply_report_en <= 1'b0;
    apply(16'h0000, 16'h0800);
    cmp_bit(f_force, 1'b0);
    clear_all();
    pwm_mode <= 1'b0;
    clip_raw <= 1'b1;
    apply(16'h8000, 16'h0000);
    cmp_bit(f_force, 1'b0);
    cmp_word({4'h0, m_data}, 16'h080A);
    clear_all();
    pwm_mode <= 1'b1;
    variant_fixed <= 1'b1;
    std_lvl <= 10'($urandom_range(900, 30));
    mag_lvl <= 10'($urandom_range(900, 30));
    apply(16'h0010, 16'h0000);
    cmp_duty(duty, mag_lvl);
    clear_all();
    apply(16'h0080, 16'h0000);
    cmp_duty(duty, std_lvl);
    clear_all();
    variant_fixed <= 1'b0;
    p_raw <= 16'h0008;
    @(posedge clk);
    p_raw <= 16'h0004;
    status_clear <= 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    cmp_word(st_p, 16'h0004);
    clear_all();
    for (int k = 0; k < 12; k++) begin
      apply(16'($urandom()), 16'($urandom()) & 16'h4F00);
      cmp_word(st_p, exp_p);
      cmp_word(st_s, exp_s);
    end
    for (int j = 0; j < 4; j++) begin
      clear_all();
      apply(16'h0000, 16'h0001 << fatal[j]);
      for (int w = 0; w < 20 && rst_req !== 1'b1; w++)
        @(negedge clk);
      cmp_bit(rst_req, 1'b1);
      cmp_word(st_s, 16'h0000);
      @(posedge clk);
      s_raw <= 16'h0000;
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
    end
    complete_run();
  end
endmodule : tb_top
